//--- hdl/fbs_pin_sync.sv
// two-flop synchroniser with edge pulses for one pin
`timescale 1ns/1ps
module fbs_pin_sync
  import fbs_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pin side
  input wire logic pin,
  // synchronised side
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;

endmodule : fbs_pin_sync

//--- hdl/fbs_pkg.sv
// shared constants and types for the fuse readback and sense block
package fbs_pkg;

  // clock and serial bit timing
  localparam int FBS_CLK_PERIOD_PS = 5000;
  localparam int FBS_BIT_ONE_MIN_NS = 30000;
  localparam int FBS_ONE_MIN_CYC =
    (FBS_BIT_ONE_MIN_NS * 1000 + FBS_CLK_PERIOD_PS - 1) / FBS_CLK_PERIOD_PS;
  localparam int FBS_HI_CNT_W = 16;

  // packet layout and patterns
  localparam int FBS_PKT_LEN = 38;
  localparam logic [11:0] FBS_START_PAT = 12'h801;
  localparam logic [11:0] FBS_END_PAT = 12'h7fe;
  localparam logic [1:0] FBS_FN_SENSE = 2'h0;
  localparam logic [1:0] FBS_FN_READ = 2'h3;
  localparam logic [1:0] FBS_PAR_GAIN2 = 2'h0;
  localparam logic [1:0] FBS_PAR_GAIN1 = 2'h1;
  localparam logic [1:0] FBS_PAR_OFFSET = 2'h2;
  localparam logic [1:0] FBS_PAR_OTHER = 2'h3;

  // readback shifter
  localparam int FBS_RB_BITS = 8;
  localparam logic [2:0] FBS_RB_LAST = 3'h7;

  // register map (byte addresses) and reset values
  localparam logic [7:0] FBS_REG_CTRL = 8'h00;
  localparam logic [7:0] FBS_REG_STATUS = 8'h04;
  localparam logic [7:0] FBS_REG_LASTCMD = 8'h08;
  localparam logic [7:0] FBS_ADDR_MASK = 8'hfc;
  localparam logic FBS_CTRL_EN_RST = 1'b1;

  typedef struct packed {
    logic [11:0] start;
    logic [1:0] func;
    logic [1:0] param;
    logic [1:0] dummy;
    logic [7:0] value;
    logic [11:0] stop;
  } fbs_pkt_t;

  // sensed fuse cell outputs, 1 = blown
  typedef struct packed {
    logic [2:0] gain2;
    logic [6:0] gain1;
    logic [7:0] offset;
    logic [1:0] other;
  } fbs_fuse_t;

endpackage : fbs_pkg

//--- hdl/fbs_readback_ctrl.sv
// fuse readback, sense current select and register slave
`timescale 1ns/1ps
// Contract
// - read function code 11 enters readback; parameter selects, value ignored
// - entry loads selected fuse bits into 8-bit shifter, msb on output
// - each falling input edge in readback before the eighth shifts toward the output
// - eighth pulse after entry detaches shifter and leaves readback
// - narrow parameters are padded with zeros in the upper positions
// - outside readback the output carries only the second stage signal
// - function 00 parameter 00 sets low sense current from value bit 0
// - sense selection is volatile and resets to normal level
// - a blown fuse reads 1, an intact fuse reads 0
// - command is 38 bits: start, function, parameter, dummy, value, end
// - packet accepted only if start and end patterns both match
// - parameter 00 gain2, 01 gain1, 10 offset, 11 other functions
module fbs_readback_ctrl
  import fbs_pkg::*;
#(
  parameter int ONE_MIN_CYC = FBS_ONE_MIN_CYC
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial pin and analog side
  input wire logic serial_program_input,
  input wire logic stage2_signal,
  input wire fbs_fuse_t fuse_cells,
  // outputs
  output logic readback_output,
  output logic buffered_amp_output,
  output logic sense_low
);
  logic pin_s;
  logic pin_rise;
  logic pin_fall;
  logic stage2_s;

  fbs_pin_sync u_pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(serial_program_input),
    .level(pin_s),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  fbs_pin_sync u_stage2_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(stage2_signal),
    .level(stage2_s),
    .rise(),
    .fall()
  );

  logic [FBS_HI_CNT_W-1:0] hi_cnt_q;
  fbs_pkt_t win_q;
  fbs_pkt_t last_q;
  logic rb_active_q;
  logic [FBS_RB_BITS-1:0] shreg_q;
  logic [2:0] rb_cnt_q;
  logic sense_low_q;
  logic out_q;
  logic en_q;
  logic [7:0] acc_cnt_q;

  // a long high pulse is a 1, a short one a 0
  localparam logic [FBS_HI_CNT_W-1:0] ONE_MIN =
    FBS_HI_CNT_W'(ONE_MIN_CYC);
  wire bit_val = hi_cnt_q >= ONE_MIN;
  wire hi_sat = &hi_cnt_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hi_cnt_q <= '0;
    else if (pin_rise)
      hi_cnt_q <= FBS_HI_CNT_W'(1);
    else if (pin_s && !hi_sat)
      hi_cnt_q <= hi_cnt_q + FBS_HI_CNT_W'(1);
  end

  // packet window slides one bit per pulse; ignored during readback
  wire fbs_pkt_t win_nx = {win_q[FBS_PKT_LEN-2:0], bit_val};
  wire pkt_take = pin_fall && !rb_active_q && en_q;
  wire pkt_match = win_nx.start == FBS_START_PAT &&
    win_nx.stop == FBS_END_PAT;
  wire pkt_ok = pkt_take && pkt_match;
  wire cmd_read = pkt_ok && win_nx.func == FBS_FN_READ;
  wire cmd_sense = pkt_ok && win_nx.func == FBS_FN_SENSE &&
    win_nx.param == FBS_PAR_GAIN2;
  wire rb_step = rb_active_q && pin_fall;
  wire rb_done = rb_step && rb_cnt_q == FBS_RB_LAST;

  // selected fuse bits, zero padded above the field
  logic [FBS_RB_BITS-1:0] fuse_sel;
  always_comb
  begin
    unique case (win_nx.param)
      FBS_PAR_GAIN2: fuse_sel = {5'h00, fuse_cells.gain2};
      FBS_PAR_GAIN1: fuse_sel = {1'h0, fuse_cells.gain1};
      FBS_PAR_OFFSET: fuse_sel = fuse_cells.offset;
      FBS_PAR_OTHER: fuse_sel = {6'h00, fuse_cells.other};
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      win_q <= '0;
    else if (pkt_ok || (rb_active_q && pin_fall))
      win_q <= '0;
    else if (pkt_take)
      win_q <= win_nx;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_q <= '0;
      acc_cnt_q <= 8'h00;
    end
    else if (pkt_ok)
    begin
      last_q <= win_nx;
      acc_cnt_q <= acc_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rb_active_q <= 1'b0;
      shreg_q <= '0;
      rb_cnt_q <= 3'h0;
    end
    else if (cmd_read)
    begin
      rb_active_q <= 1'b1;
      shreg_q <= fuse_sel;
      rb_cnt_q <= 3'h0;
    end
    else if (rb_done)
      rb_active_q <= 1'b0;
    else if (rb_step)
    begin
      shreg_q <= {shreg_q[FBS_RB_BITS-2:0], 1'b0};
      rb_cnt_q <= rb_cnt_q + 3'h1;
    end
  end

  // plain flop, so power-up always returns the normal sense level
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sense_low_q <= 1'b0;
    else if (cmd_sense)
      sense_low_q <= win_nx.value[0];
  end

  // one cycle of output lag keeps the pin glitch free
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      out_q <= 1'b0;
    else
      out_q <= rb_active_q ? shreg_q[FBS_RB_BITS-1] : stage2_s;
  end

  assign readback_output = out_q;
  assign buffered_amp_output = out_q;
  assign sense_low = sense_low_q;

  // ahb-lite slave, zero wait states, always okay
  logic dph_q;
  logic dph_wr_q;
  logic [7:0] dph_addr_q;
  wire aph = hsel && htrans[1] && hready;
  wire [7:0] a_word = haddr & FBS_ADDR_MASK;
  wire wr_ctrl = dph_q && dph_wr_q && dph_addr_q == FBS_REG_CTRL;
  // shifter sits in the top byte so the flag bits keep fixed low positions
  wire [31:0] status_w = {shreg_q, 5'h00, rb_cnt_q, acc_cnt_q, 6'h00,
    sense_low_q, rb_active_q};
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (a_word == FBS_REG_CTRL)
      rd_mux = {31'h0000_0000, en_q};
    else if (a_word == FBS_REG_STATUS)
      rd_mux = status_w;
    else if (a_word == FBS_REG_LASTCMD)
      rd_mux = {6'h00, last_q[25:0]};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_q <= 1'b0;
      dph_wr_q <= 1'b0;
      dph_addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
    end
    else if (hready)
    begin
      dph_q <= aph;
      dph_wr_q <= hwrite;
      dph_addr_q <= a_word;
      hrdata <= (aph && !hwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      en_q <= FBS_CTRL_EN_RST;
    else if (wr_ctrl)
      en_q <= hwdata[0];
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  a_rb_entry: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_read |=> rb_active_q && rb_cnt_q == 3'h0 && shreg_q == $past(fuse_sel))
    else $error("readback entry did not load");
  a_pad_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_read && win_nx.param == FBS_PAR_GAIN2 |=> shreg_q[7:3] == 5'h00)
    else $error("upper bits not zero padded");
  a_fuse_offset: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_read && win_nx.param == FBS_PAR_OFFSET
    |=> shreg_q == $past(fuse_cells.offset))
    else $error("fuse bits not loaded as sensed");
  a_rb_shift: assert property (@(posedge hclk) disable iff (!hresetn)
    rb_step && !rb_done |=> rb_active_q &&
    shreg_q == {$past(shreg_q[6:0]), 1'b0})
    else $error("readback shift wrong");
  a_rb_exit: assert property (@(posedge hclk) disable iff (!hresetn)
    rb_done |=> !rb_active_q ##1 out_q == $past(stage2_s))
    else $error("readback did not end on eighth pulse");
  a_out_mux: assert property (@(posedge hclk) disable iff (!hresetn)
    rb_active_q |=> out_q == $past(shreg_q[7]))
    else $error("readback output mismatch");
  a_sense_set: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_sense |=> sense_low_q == $past(win_nx.value[0]) && !rb_active_q)
    else $error("sense select not taken");
  a_sense_reset: assert property (@(posedge hclk)
    $rose(hresetn) |-> !sense_low_q)
    else $error("sense not normal after reset");
  a_bad_packet: assert property (@(posedge hclk) disable iff (!hresetn)
    pkt_take && !pkt_match |=> !rb_active_q && $stable(sense_low_q))
    else $error("invalid packet decoded");

endmodule : fbs_readback_ctrl

//--- sim/fbs_prog_model.sv
// serial programmer model driving the pulse-width input pin
`timescale 1ns/1ps
module fbs_prog_model
  import fbs_pkg::*;
#(
  parameter int ONE_MIN_CYC = 8
)
(
  // clock
  input wire logic hclk,
  // pin
  output logic pin
);
  initial pin = 1'b0;
  // a one stays high past the threshold, a zero well below it
  task automatic pulse(input logic b);
    @(posedge hclk);
    pin <= 1'b1;
    repeat (b ? ONE_MIN_CYC + 4 : 3) @(posedge hclk);
    pin <= 1'b0;
    // long low lets sync and shifter settle before the next bit
    repeat (10) @(posedge hclk);
  endtask : pulse
  // never sends program commands, so no fuse is tried twice
  task automatic send(input fbs_pkt_t p);
    logic [37:0] w;
    w = p;
    for (int i = 37; i >= 0; i--)
    begin
      pulse(w[i]);
    end
  endtask : send
endmodule : fbs_prog_model

//--- sim/testbench.sv
// self-checking bench for the fuse readback and sense controller
`timescale 1ns/1ps
module testbench;
  import fbs_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd_s, r;
  logic pin, stage2, rdo, amp, slo, sel, eb;
  fbs_fuse_t fuse;
  logic qb[$];
  logic [63:0] qw[$];
  event ev_b, ev_w;
  int n_mismatch = 0;
  int num_checks = 0;
  int seed = 32'h3e4dcf22;
  assign hready = hreadyout;
  fbs_readback_ctrl #(.ONE_MIN_CYC(8)) dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .serial_program_input(pin), .stage2_signal(stage2),
    .fuse_cells(fuse), .readback_output(rdo),
    .buffered_amp_output(amp), .sense_low(slo));
  fbs_prog_model #(.ONE_MIN_CYC(8)) prog (.hclk(hclk), .pin(pin));
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) rd_s <= hrdata;
  always @(ev_b)
  begin
    eb = qb.pop_front();
    chk_b(eb, sel ? slo : rdo);
    if (!sel)
      chk_b(eb, amp);
  end
  always @(ev_w)
  begin
    chk_w(qw.pop_front(), r);
    chk_b(1'b0, hresp);
  end
  task automatic chk_b(input logic e, input logic g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: pin %b want %b", $time, g, e);
    end
  endtask : chk_b
  task automatic chk_w(input logic [63:0] m, input logic [31:0] g);
    num_checks++;
    if ((g & m[63:32]) !== m[31:0])
    begin
      n_mismatch++;
      $display("unexpected at %0t: word %h", $time, g);
    end
  endtask : chk_w
  // sample away from the rising edge so outputs have settled
  task automatic note_b(input logic s, input logic e);
    @(negedge hclk);
    sel = s;
    qb.push_back(e);
    ->ev_b;
  endtask : note_b
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hready !== 1'b1)
    begin
      k++;
      if (k > 50)
      begin
        n_mismatch++;
        end_sim();
      end
      @(posedge hclk);
    end
  endtask : rdy
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    #1 r = rd_s;
  endtask : ahb
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    qw.push_back({m, e});
    ->ev_w;
  endtask : rd
  function automatic fbs_pkt_t pk(input logic [1:0] f, p,
    input logic [7:0] x);
    return {FBS_START_PAT, f, p, 2'h2, x, FBS_END_PAT};
  endfunction : pk
  task automatic rb(input logic [1:0] p);
    stage2 <= 1'($random(seed));
    v = p == 2'h0 ? {5'h0, fuse.gain2} : p == 2'h1 ? {1'b0, fuse.gain1}
      : p == 2'h2 ? fuse.offset : {6'h0, fuse.other};
    prog.send(pk(FBS_FN_READ, p, 8'($random(seed))));
    note_b(1'b0, v[7]);
    for (int i = 6; i >= 0; i--)
    begin
      prog.pulse(1'b0);
      note_b(1'b0, v[i]);
    end
    prog.pulse(1'b0);
    note_b(1'b0, stage2);
  endtask : rb
  initial
  begin
    #400000;
    n_mismatch++;
    end_sim();
  end
  initial
  begin
    {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    sel = 1'b0;
    stage2 = 1'b1;
    fuse = 20'($random(seed));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(FBS_REG_CTRL, 32'h1, 32'h1);
    rd(8'h0c, 32'hffffffff, 32'h0);
    note_b(1'b1, 1'b0);
    note_b(1'b0, stage2);
    prog.send(pk(FBS_FN_SENSE, FBS_PAR_GAIN2, 8'hff) ^ 38'h2);
    note_b(1'b1, 1'b0);
    prog.send(pk(FBS_FN_SENSE, FBS_PAR_GAIN2, 8'h55));
    note_b(1'b1, 1'b1);
    rd(FBS_REG_STATUS, 32'h0000_ff03, 32'h0000_0102);
    rd(FBS_REG_LASTCMD, 32'h03ff_ffff,
      {6'h00, 26'(pk(FBS_FN_SENSE, FBS_PAR_GAIN2, 8'h55))});
    for (int p = 0; p < 4; p++)
    begin
      rb(2'(p));
    end
    prog.send(pk(FBS_FN_SENSE, FBS_PAR_GAIN2, 8'hfe));
    note_b(1'b1, 1'b0);
    for (int p = 0; p < 4; p++)
    begin
      rb(2'(p));
    end
    ahb(1'b1, FBS_REG_CTRL, 32'h0);
    prog.send(pk(FBS_FN_READ, FBS_PAR_GAIN2, 8'h0));
    rd(FBS_REG_STATUS, 32'h0000_ff01, 32'h0000_0a00);
    note_b(1'b0, stage2);
    ahb(1'b1, FBS_REG_CTRL, 32'h1);
    prog.send(pk(FBS_FN_SENSE, FBS_PAR_GAIN1, 8'h01));
    note_b(1'b1, 1'b0);
    prog.send(pk(FBS_FN_SENSE, FBS_PAR_GAIN2, 8'h01));
    note_b(1'b1, 1'b1);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    note_b(1'b1, 1'b0);
    end_sim();
  end
endmodule : testbench
